// [tlms_seq.sv]
// phase generator and address sequencer for a two-level analog mux
`timescale 1ns/10ps
`default_nettype none
`include "tlms_map.svh"

// Behaviour
// - one phase and counter per first-level mux
// - 4-bit address counters wrap through sixteen channels
// - four phases from two-bit counter plus decode
// - phase counter advances on sampling clock pin falling edge
// - each counter state decodes to one phase
// - phase low closes switch; one low at most
// - phase rising opens switch, steps its address
// - mux readdresses only in the all-open gap after its own phase
// - second-level switches close in fixed order
// - outgoing switch opens before incoming closes
// - reset starts on first channel, first mux
module tlms_seq (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// sampling clock pin
	input wire logic seq_clk_i,
	// second-level switch phases, low closes the switch
	output logic [`TLMS_NUM_MUX-1:0] phase_n_o,
	// first-level channel addresses
	output tlms_pkg::tlms_addr_s addr_o
);

	import tlms_pkg::*;

	// ==========================================================
	// pin synchroniser and falling edge detect
	logic clk_s1_r;
	logic clk_s2_r;
	logic clk_s3_r;
	wire adv_w;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
		end else begin
			clk_s1_r <= seq_clk_i;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
		end
	end

	// only the high-to-low transition moves the sequence
	assign adv_w = clk_s3_r & ~clk_s2_r;

	// ==========================================================
	// two-bit phase counter
	tlms_ph_t ph_cnt_r;
	tlms_ph_t ph_cnt_nxt;
	logic brk_r;

	// counter built as two toggling stages
	assign ph_cnt_nxt = {ph_cnt_r[1] ^ ph_cnt_r[0], ~ph_cnt_r[0]};

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ph_cnt_r <= `TLMS_PH_CNT_RST;
			brk_r <= 1'b0;
		end else begin
			brk_r <= adv_w;
			if (adv_w) begin
				ph_cnt_r <= ph_cnt_nxt;
			end
		end
	end

	// ==========================================================
	// phase decode
	// a one-cycle all-open gap costs 10 ns but keeps two
	// first-level outputs from ever shorting together
	wire [`TLMS_NUM_MUX-1:0] dec_n_w;
	wire [`TLMS_NUM_MUX-1:0] phase_nxt;
	logic [`TLMS_NUM_MUX-1:0] phase_n_r;

	genvar gi;
	generate
		for (gi = 0; gi < `TLMS_NUM_MUX; gi++) begin : g_dec
			assign dec_n_w[gi] = (ph_cnt_r != 2'(gi));
		end
	endgenerate

	assign phase_nxt = adv_w ? `TLMS_PHASE_OFF :
		(brk_r ? dec_n_w : phase_n_r);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_n_r <= `TLMS_PHASE_RST;
		end else begin
			phase_n_r <= phase_nxt;
		end
	end

	assign phase_n_o = phase_n_r;

	// ==========================================================
	// channel address counters, one per first-level mux
	wire [`TLMS_NUM_MUX-1:0] step_w;
	// a net takes the four counter outputs, one driver per member
	wire tlms_addr_s addr_w;

	generate
		for (gi = 0; gi < `TLMS_NUM_MUX; gi++) begin : g_mux
			// step as the phase opens; the next mux is then sampled
			assign step_w[gi] = adv_w & (ph_cnt_r == 2'(gi));
			tlms_addr_ctr u_ctr (
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.step_i(step_w[gi]),
				.chan_o(addr_w.chan[gi])
			);
		end
	endgenerate

	assign addr_o = addr_w;

	// ==========================================================
	// rotation reference for the order checks
	// kept apart from the phase counter so a decode slip shows up
	tlms_ph_t exp_ph_r;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exp_ph_r <= `TLMS_PH_CNT_RST;
		end else if (brk_r) begin
			exp_ph_r <= exp_ph_r + 2'h1;
		end
	end

	// ==========================================================
	// checks
	a_one_low: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$onehot0(~phase_n_r))
		else $error("more than one phase low");
	a_break_first: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		adv_w |=> phase_n_r == `TLMS_PHASE_OFF ##1 $onehot(~phase_n_r))
		else $error("break-before-make gap missing");
	a_no_overlap: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$changed(phase_n_r) && phase_n_r != `TLMS_PHASE_OFF
		|-> $past(phase_n_r) == `TLMS_PHASE_OFF)
		else $error("phase closed without prior open");
	a_gap_short: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		phase_n_r == `TLMS_PHASE_OFF |=> phase_n_r != `TLMS_PHASE_OFF)
		else $error("all-open gap longer than one cycle");
	a_dec_match: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		phase_n_r != `TLMS_PHASE_OFF |-> phase_n_r == dec_n_w)
		else $error("closed phase differs from counter state");
	a_rot_ref: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		phase_n_r != `TLMS_PHASE_OFF |-> !phase_n_r[exp_ph_r])
		else $error("closed phase out of rotation");
	a_pin_fall: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		adv_w == ($past(seq_clk_i, 3) && !$past(seq_clk_i, 2)))
		else $error("advance does not follow a pin fall");
	a_fall_adv: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		adv_w |=> ph_cnt_r == $past(ph_cnt_r) + 2'h1)
		else $error("phase counter did not advance");
	a_cnt_hold: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!adv_w |=> $stable(ph_cnt_r))
		else $error("phase counter moved without falling edge");
	a_phase_order: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		brk_r |=> ~phase_n_r == (4'h1 << $past(ph_cnt_r)))
		else $error("wrong phase selected");
	a_step_owner: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		|step_w |-> $onehot(step_w) && !phase_n_r[ph_cnt_r])
		else $error("address step on wrong mux");
	a_reset_start: assert property (
		@(posedge core_clk_i)
		$fell(sys_rst_i) |-> phase_n_r == `TLMS_PHASE_RST
		&& ph_cnt_r == `TLMS_PH_CNT_RST && addr_o == '0)
		else $error("not at first channel after reset");

	// ==========================================================
	// per-mux checks
	generate
		for (gi = 0; gi < `TLMS_NUM_MUX; gi++) begin : g_chk
			// a mux moves only as its own phase has just opened
			a_mux_step: assert property (
				@(posedge core_clk_i) disable iff (sys_rst_i)
				$rose(phase_n_r[gi]) |->
				addr_o.chan[gi] == $past(addr_o.chan[gi]) + 4'h1)
				else $error("mux address did not step as its phase opened");
			a_mux_quiet: assert property (
				@(posedge core_clk_i) disable iff (sys_rst_i)
				$changed(addr_o.chan[gi]) |-> phase_n_r[gi]
				&& !$past(phase_n_r[gi]))
				else $error("mux address changed while routed");
			a_mux_order: assert property (
				@(posedge core_clk_i) disable iff (sys_rst_i)
				$fell(phase_n_r[gi]) |->
				!$past(phase_n_r[(gi + `TLMS_NUM_MUX - 1) % `TLMS_NUM_MUX], 2))
				else $error("phase closed out of rotation order");
		end
	endgenerate

	c_full_cycle: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		adv_w && ph_cnt_r == 2'h3);
	c_break: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		brk_r ##1 !phase_n_r[0]);
	c_step_mux3: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		step_w[3]);

endmodule : tlms_seq
`default_nettype wire

// [tlms_map.svh]
// offsets-free constant map for the two-level mux sequencer
`ifndef TLMS_MAP_SVH
`define TLMS_MAP_SVH

// ==========================================================
// sizes
`define TLMS_NUM_MUX 4
`define TLMS_ADDR_W 4
`define TLMS_PH_W 2

// ==========================================================
// reset values and the all-open phase pattern
`define TLMS_PH_CNT_RST 2'h0
`define TLMS_PHASE_RST 4'hE
`define TLMS_PHASE_OFF 4'hF
`define TLMS_ADDR_RST 4'h0

`endif

// [tlms_pkg.sv]
// types shared by the two-level mux sequencer
`default_nettype none
`include "tlms_map.svh"

package tlms_pkg;

	typedef logic [`TLMS_ADDR_W-1:0] tlms_chan_t;
	typedef logic [`TLMS_PH_W-1:0] tlms_ph_t;

	// one channel address per first-level multiplexer
	typedef struct packed {
		tlms_chan_t [`TLMS_NUM_MUX-1:0] chan;
	} tlms_addr_s;

endpackage : tlms_pkg
`default_nettype wire

// [tlms_addr_ctr.sv]
// recirculating channel address counter for one first-level mux
`timescale 1ns/10ps
`default_nettype none
`include "tlms_map.svh"

module tlms_addr_ctr (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// step request
	input wire logic step_i,
	// channel address
	output logic [`TLMS_ADDR_W-1:0] chan_o
);

	logic [`TLMS_ADDR_W-1:0] chan_r;
	logic [`TLMS_ADDR_W-1:0] chan_nxt;

	// ==========================================================
	// counter
	// natural wrap from 15 to 0 covers all sixteen inputs
	assign chan_nxt = step_i ? chan_r + 4'h1 : chan_r;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chan_r <= `TLMS_ADDR_RST;
		end else begin
			chan_r <= chan_nxt;
		end
	end

	assign chan_o = chan_r;

	// ==========================================================
	// checks
	a_chan_step: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		step_i |=> chan_r == $past(chan_r) + 4'h1)
		else $error("address counter did not step by one");
	a_chan_hold: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!step_i |=> $stable(chan_r))
		else $error("address changed without a step");
	c_chan_wrap: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		step_i && chan_r == 4'hF ##1 chan_r == 4'h0);

endmodule : tlms_addr_ctr
`default_nettype wire

// [tlms_sw_model.sv]
// far-side model: second-level switch bank over four first-level muxes
`timescale 1ns/10ps
`default_nettype none
module tlms_sw_model (
	// switch controls, low closes
	input wire logic [3:0] phase_n_i,
	input wire tlms_pkg::tlms_addr_s addr_i,
	// routed channel number
	output logic [5:0] chan_o,
	output logic on_o
);
	import tlms_pkg::*;
	// ==========================================
	// routing
	assign on_o = (phase_n_i != 4'hF);
	always_comb begin
		chan_o = 6'h00;
		for (int i = 0; i < 4; i++) begin
			if (!phase_n_i[i]) begin
				chan_o = {i[1:0], addr_i.chan[i]};
			end
		end
	end
endmodule : tlms_sw_model
`default_nettype wire

// [two_level_mux_sequencer_tb.sv]
// self-checking bench for the two-level mux sequencer
`timescale 1ns/10ps
`default_nettype none
module two_level_mux_sequencer_tb;
	import tlms_pkg::*;
	// ==========================================
	// signals
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic seq_clk = 1'b1;
	logic [3:0] phase_n;
	tlms_addr_s addr;
	logic [5:0] routed;
	logic routed_on;
	int failures = 0;
	int comparisons = 0;
	int seed = 32'hF591;
	int k = 0;
	logic [3:0] ex [4];
	always #5 core_clk = ~core_clk;
	tlms_seq dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
		.seq_clk_i(seq_clk), .phase_n_o(phase_n), .addr_o(addr));
	tlms_sw_model sw (.phase_n_i(phase_n), .addr_i(addr),
		.chan_o(routed), .on_o(routed_on));
	// ==========================================
	// helpers
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// invert at four bits so the upper bits stay clear
	function automatic logic [15:0] ph_exp(input int i);
		logic [3:0] p;
		p = ~(4'h1 << i);
		return {12'h000, p};
	endfunction : ph_exp
	function automatic logic [15:0] addr_exp();
		return {ex[3], ex[2], ex[1], ex[0]};
	endfunction : addr_exp
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// pin held high here so release never looks like a fall
	task automatic do_reset(input int n);
		sys_rst = 1'b1;
		repeat (n) @(negedge core_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 4; i++) ex[i] = 4'h0;
		k = 0;
		@(negedge core_clk);
		check("phase_n", 16'h000E, 16'(phase_n));
		check("addr", 16'h0000, addr);
		$display("reset test done");
	endtask : do_reset
	// one falling edge of the sampling pin, random low and high spans
	task automatic fall();
		int n;
		seq_clk = 1'b0;
		n = 0;
		while (phase_n !== 4'hF && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		ex[k] = ex[k] + 4'h1;
		check("phase_n open", 16'h000F, 16'(phase_n));
		check("routed on", 16'h0000, 16'(routed_on));
		check("addr step", addr_exp(), addr);
		k = (k + 1) % 4;
		@(negedge core_clk);
		check("phase_n", ph_exp(k), 16'(phase_n));
		check("routed on", 16'h0001, 16'(routed_on));
		check("routed", 16'({k[1:0], ex[k]}), 16'(routed));
		repeat (2 + ($unsigned($random(seed)) % 4)) @(negedge core_clk);
		seq_clk = 1'b1;
		repeat (3 + ($unsigned($random(seed)) % 5)) @(negedge core_clk);
		check("phase_n hold", ph_exp(k), 16'(phase_n));
		check("addr hold", addr_exp(), addr);
	endtask : fall
	// ==========================================
	// sequence and watchdog
	initial begin
		do_reset(8);
		for (int i = 0; i < 100; i++) begin
			if (i == 30) do_reset(2);
			fall();
		end
		$display("rotation test done");
		finish_test();
	end
	initial begin
		#200000;
		failures++;
		finish_test();
	end
endmodule : two_level_mux_sequencer_tb
`default_nettype wire
